// ### hdl/sensor_page_map.vh
`ifndef SENSOR_PAGE_MAP_VH
`define SENSOR_PAGE_MAP_VH
// Interface pages
`define PAGE_ADC 4'h0
`define PAGE_CTRL 4'h2
// Page 0 offsets
`define OFS_PRESSURE_LOW 8'h10
`define OFS_PRESSURE_HIGH 8'h11
`define OFS_TEMPERATURE_LOW 8'h14
`define OFS_TEMPERATURE_HIGH 8'h15
// Page 2 offsets
`define OFS_OUTPUT_LOW 8'h30
`define OFS_OUTPUT_HIGH 8'h31
`define OFS_OFFSET_TRIM 8'h4e
// Reset values
`define RST_BYTE 8'h00
`define RST_OUTPUT 12'h000
`define RST_TRIM 5'h00
`define RST_OUT_HIGH 4'h0
`define RST_UV 16'h0000
`define RST_POS_EN 1'b0
// Zero trim selects the negative pin
`define RST_NEG_EN 1'b1
// Offset trim fields
`define TRIM_MAG_MSB 3
`define TRIM_MAG_LSB 0
`define TRIM_POL_BIT 4
// Output value high register fields
`define OUT_HIGH_MSB 3
// Offset step, microvolts per code
`define OFFSET_STEP_UV 16'h0e42
`endif

// ### hdl/adc_result_shadow.v
`timescale 1ns/100ps
`default_nettype none
`include "sensor_page_map.vh"

module adc_result_shadow (
   input wire clk_i,
   input wire resetn_i,
   input wire [15:0] live_i,
   input wire low_read_i,
   output wire [7:0] low_o,
   output wire [7:0] high_o
);

   reg [7:0] high_q;

   assign low_o = live_i[7:0];
   assign high_o = high_q;

   always @(posedge clk_i) begin
      if (!resetn_i) begin
         high_q <= `RST_BYTE;
      end else if (low_read_i) begin
         // Held until next low read, whatever conversions land meanwhile
         high_q <= live_i[15:8];
      end
   end

endmodule
`default_nettype wire

// ### hdl/sensor_register_page.v
//
// Summary of operation
// - Four-bit code sets offset in 3.65 mV steps.
// - Bit four of trim selects polarity.
// - Low-byte read latches matching high byte.
// - Pressure high read returns shadow copy.
// - Temperature result uses same shadow scheme.
// - Pressure result: two read-only bytes, reset zero.
// - Temperature result: two read-only bytes, reset zero.
// - Twelve-bit output value split low byte/high nibble.
// - Output registers read-write, reset zero, reserved top.
// - ADC on page zero; trim, output on two.
//
`timescale 1ns/100ps
`default_nettype none
`include "sensor_page_map.vh"

module sensor_register_page (
   input wire clk_i,
   input wire resetn_i,
   input wire [3:0] page_i,
   input wire [7:0] offset_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] wdata_i,
   output wire [7:0] rdata_o,
   output wire hit_o,
   input wire [15:0] pressure_conversion_result_i,
   input wire [15:0] temperature_conversion_result_i,
   input wire conversion_valid_i,
   output wire [11:0] output_converter_value_o,
   output wire [3:0] offset_magnitude_code_o,
   output wire [15:0] offset_microvolts_o,
   output wire bridge_positive_input_pin_en_o,
   output wire bridge_negative_input_pin_en_o
);

   ////////////////////////////////////////////////////////////////////////
   // Decode

   function sel;
      input [3:0] pg;
      input [7:0] ofs;
      input [3:0] want_pg;
      input [7:0] want_ofs;
      begin
         sel = (pg == want_pg) && (ofs == want_ofs);
      end
   endfunction

   // One entry per register, page in the top nibble, offset below it
   localparam NUM_REGS = 7;
   localparam [12*NUM_REGS-1:0] REG_ADDR = {
      `PAGE_CTRL, `OFS_OFFSET_TRIM,
      `PAGE_CTRL, `OFS_OUTPUT_HIGH,
      `PAGE_CTRL, `OFS_OUTPUT_LOW,
      `PAGE_ADC, `OFS_TEMPERATURE_HIGH,
      `PAGE_ADC, `OFS_TEMPERATURE_LOW,
      `PAGE_ADC, `OFS_PRESSURE_HIGH,
      `PAGE_ADC, `OFS_PRESSURE_LOW
   };

   wire [NUM_REGS-1:0] hits;

   genvar r;
   generate
      for (r = 0; r < NUM_REGS; r = r + 1) begin : g_decode
         assign hits[r] = sel(page_i, offset_i,
            REG_ADDR[12*r+11:12*r+8], REG_ADDR[12*r+7:12*r]);
      end
   endgenerate

   wire hit_pl = hits[0];
   wire hit_ph = hits[1];
   wire hit_tl = hits[2];
   wire hit_th = hits[3];
   wire hit_ol = hits[4];
   wire hit_oh = hits[5];
   wire hit_tr = hits[6];

   assign hit_o = |hits;

   ////////////////////////////////////////////////////////////////////////
   // Live results, captured per conversion so reset reads zero

   reg [15:0] pressure_q;
   reg [15:0] temperature_q;

   always @(posedge clk_i) begin
      if (!resetn_i) begin
         pressure_q <= 16'h0000;
         temperature_q <= 16'h0000;
      end else if (conversion_valid_i) begin
         pressure_q <= pressure_conversion_result_i;
         temperature_q <= temperature_conversion_result_i;
      end
   end

   wire [7:0] p_low;
   wire [7:0] p_high;
   wire [7:0] t_low;
   wire [7:0] t_high;

   // Host must read low byte first to get a coherent pair
   adc_result_shadow u_pressure_shadow (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .live_i(pressure_q),
      .low_read_i(rd_i & hit_pl),
      .low_o(p_low),
      .high_o(p_high)
   );

   adc_result_shadow u_temperature_shadow (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .live_i(temperature_q),
      .low_read_i(rd_i & hit_tl),
      .low_o(t_low),
      .high_o(t_high)
   );

   ////////////////////////////////////////////////////////////////////////
   // Writable registers

   reg [7:0] out_low_q;
   reg [3:0] out_high_q;
   reg [4:0] trim_q;

   // Writes to read-only or unmapped locations raise no write enable and are lost
   wire out_low_wr = wr_i & hit_ol;
   wire out_high_wr = wr_i & hit_oh;
   wire trim_wr = wr_i & hit_tr;

   always @(posedge clk_i) begin
      if (!resetn_i) begin
         out_low_q <= `RST_BYTE;
      end else if (out_low_wr) begin
         out_low_q <= wdata_i;
      end
   end

   always @(posedge clk_i) begin
      if (!resetn_i) begin
         out_high_q <= `RST_OUT_HIGH;
      end else if (out_high_wr) begin
         // Reserved top nibble is dropped here and reads back as zero
         out_high_q <= wdata_i[`OUT_HIGH_MSB:0];
      end
   end

   always @(posedge clk_i) begin
      if (!resetn_i) begin
         trim_q <= `RST_TRIM;
      end else if (trim_wr) begin
         trim_q <= wdata_i[`TRIM_POL_BIT:0];
      end
   end

   assign output_converter_value_o = {out_high_q, out_low_q};

   ////////////////////////////////////////////////////////////////////////
   // Offset cancellation

   // Nominal only; the analog table rounds a few codes differently
   function [15:0] code_to_uv;
      input [3:0] code;
      begin
         // Widest product, fifteen steps, still fits sixteen bits
         code_to_uv = {12'h000, code} * `OFFSET_STEP_UV;
      end
   endfunction

   reg [15:0] uv_q;
   reg pos_en_q;
   reg neg_en_q;

   // Load on the trim write edge, so they never disagree with trim_q;
   // registered so decode glitches never reach the analog switch controls
   always @(posedge clk_i) begin
      if (!resetn_i) begin
         uv_q <= `RST_UV;
         pos_en_q <= `RST_POS_EN;
         neg_en_q <= `RST_NEG_EN;
      end else if (trim_wr) begin
         uv_q <= code_to_uv(wdata_i[`TRIM_MAG_MSB:`TRIM_MAG_LSB]);
         pos_en_q <= wdata_i[`TRIM_POL_BIT];
         neg_en_q <= ~wdata_i[`TRIM_POL_BIT];
      end
   end

   assign offset_magnitude_code_o = trim_q[`TRIM_MAG_MSB:`TRIM_MAG_LSB];
   assign offset_microvolts_o = uv_q;
   assign bridge_positive_input_pin_en_o = pos_en_q;
   assign bridge_negative_input_pin_en_o = neg_en_q;

   ////////////////////////////////////////////////////////////////////////
   // Read data, registered one cycle after the read strobe

   reg [7:0] rd_d;
   reg [7:0] rdata_q;

   always @* begin
      rd_d = 8'h00;
      if (hit_pl) rd_d = p_low;
      if (hit_ph) rd_d = p_high;
      if (hit_tl) rd_d = t_low;
      if (hit_th) rd_d = t_high;
      if (hit_ol) rd_d = out_low_q;
      if (hit_oh) rd_d = {4'h0, out_high_q};
      if (hit_tr) rd_d = {3'h0, trim_q};
   end

   always @(posedge clk_i) begin
      if (!resetn_i) begin
         rdata_q <= `RST_BYTE;
      end else if (rd_i) begin
         rdata_q <= rd_d;
      end
   end

   assign rdata_o = rdata_q;

endmodule
`default_nettype wire

// ### bench/sensor_page_checker_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module sensor_page_checker (
   input wire clk_i,
   input wire resetn_i,
   input wire [3:0] page_i,
   input wire [7:0] offset_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] wdata_i,
   input wire [7:0] rdata_o,
   input wire hit_o,
   input wire [11:0] output_converter_value_o,
   input wire [3:0] offset_magnitude_code_o,
   input wire [15:0] offset_microvolts_o,
   input wire bridge_positive_input_pin_en_o,
   input wire bridge_negative_input_pin_en_o
);
   wire [11:0] dac = output_converter_value_o;
   wire [4:0] trim = {bridge_positive_input_pin_en_o, offset_magnitude_code_o};
   wire w2 = wr_i && page_i == 4'h2;
   wire r2 = rd_i && page_i == 4'h2;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   property p_uv; offset_microvolts_o == trim[3:0] * 16'h0e42; endproperty
   a_uv: assert property (p_uv) else $error("uv");
   property p_trim; w2 && offset_i == 8'h4e |=> trim == ($past(wdata_i) & 8'h1f); endproperty
   a_trim: assert property (p_trim) else $error("trim");
   property p_pol; bridge_negative_input_pin_en_o == !trim[4]; endproperty
   a_pol: assert property (p_pol) else $error("pol");
   property p_lo; w2 && offset_i == 8'h30 |=> dac[7:0] == $past(wdata_i); endproperty
   a_lo: assert property (p_lo) else $error("lo");
   property p_hi; w2 && offset_i == 8'h31 |=> dac[11:8] == ($past(wdata_i) & 8'h0f); endproperty
   a_hi: assert property (p_hi) else $error("hi");
   property p_rsv; r2 && offset_i == 8'h31 |=> rdata_o[7:4] == 4'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("rsv");
   property p_rst; $rose(resetn_i) |-> rdata_o == 8'h00 && dac == 12'h000 && trim == 5'h00;
   endproperty
   a_rst: assert property (p_rst) else $error("rst");
   property p_unm; rd_i && !hit_o |=> rdata_o == 8'h00; endproperty
   a_unm: assert property (p_unm) else $error("unm");
   c_high: cover property (rd_i && page_i == 4'h0 && offset_i == 8'h11);
   c_trim: cover property (w2 && offset_i == 8'h4e);
   c_unm: cover property (rd_i && !hit_o);
endmodule
bind sensor_register_page sensor_page_checker sensor_page_checker_inst (.*);
`default_nettype wire

// ### bench/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input wire clk_i,
   input wire [7:0] rdata_i,
   output logic [3:0] page_o,
   output logic [7:0] offset_o,
   output logic wr_o,
   output logic rd_o,
   output logic [7:0] wdata_o
);
   initial {page_o, offset_o, wr_o, rd_o, wdata_o} = 22'h0;
   // Idle edge between accesses keeps each strobe a clean pulse
   task automatic access(input logic [11:0] a, input logic w, input logic [7:0] v,
      output logic [7:0] d);
      @(negedge clk_i) {page_o, offset_o, wr_o, rd_o, wdata_o} = {a, w, !w, v};
      @(negedge clk_i) d = rdata_i;
      {wr_o, rd_o, wdata_o} = {2'b00, ~v};
   endtask
endmodule
`default_nettype wire

// ### bench/sensor_register_page_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sensor_register_page_tb;
   logic clk_i = 0, resetn_i = 0, conversion_valid_i = 0;
   logic [15:0] pressure_conversion_result_i = 16'h0, temperature_conversion_result_i = 16'h0;
   wire [3:0] page_i, offset_magnitude_code_o;
   wire [7:0] offset_i, wdata_i, rdata_o;
   wire wr_i, rd_i, hit_o, bridge_positive_input_pin_en_o, bridge_negative_input_pin_en_o;
   wire [11:0] output_converter_value_o;
   wire [15:0] offset_microvolts_o;
   wire [1:0] pins = {bridge_positive_input_pin_en_o, bridge_negative_input_pin_en_o};
   logic [11:0] map[7] = '{12'h010, 12'h011, 12'h014, 12'h015, 12'h230, 12'h231, 12'h24e};
   logic [7:0] d;
   int mismatches = 0, num_checks = 0;
   initial forever #50 clk_i = ~clk_i;
   sensor_register_page sensor_register_page_inst (.*);
   host_model host_model_inst (.clk_i(clk_i), .rdata_i(rdata_o), .page_o(page_i),
      .offset_o(offset_i), .wr_o(wr_i), .rd_o(rd_i), .wdata_o(wdata_i));
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic rw(input logic [11:0] a, input logic w, input logic [7:0] v);
      host_model_inst.access(a, w, v, d);
      if (!w) chk($sformatf("reg_%h", a), {8'h00, v}, {8'h00, d});
   endtask
   task automatic conv(input logic [15:0] p, input logic [15:0] t);
      @(negedge clk_i) {pressure_conversion_result_i, temperature_conversion_result_i} = {p, t};
      conversion_valid_i = 1;
      @(negedge clk_i) conversion_valid_i = 0;
   endtask
   task report_and_stop();
      if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge clk_i);
      mismatches++;
      report_and_stop();
   end
   initial begin
      repeat (2) @(negedge clk_i);
      resetn_i = 1;
      foreach (map[i]) rw(map[i], 0, 8'h00);
      conv(16'h1234, 16'habcd);
      rw(12'h010, 0, 8'h34);
      conv(16'h5678, 16'h9ef0);
      rw(12'h011, 0, 8'h12);
      rw(12'h014, 0, 8'hf0);
      rw(12'h015, 0, 8'h9e);
      rw(12'h010, 1, 8'hff);
      rw(12'h010, 0, 8'h78);
      rw(12'h230, 1, 8'ha5);
      rw(12'h231, 1, 8'hff);
      rw(12'h231, 0, 8'h0f);
      chk("output_converter_value_o", 16'h0fa5, {4'h0, output_converter_value_o});
      rw(12'h210, 0, 8'h00);
      chk("hit_o", 16'h0000, {15'h0, hit_o});
      rw(12'h24e, 1, 8'hff);
      rw(12'h24e, 0, 8'h1f);
      chk("hit_o", 16'h0001, {15'h0, hit_o});
      chk("pins", 16'h0002, {14'h0, pins});
      chk("offset_microvolts_o", 16'hd5de, offset_microvolts_o);
      rw(12'h24e, 1, 8'h05);
      chk("pins", 16'h0001, {14'h0, pins});
      chk("offset_microvolts_o", 16'h474a, offset_microvolts_o);
      resetn_i = 0;
      @(negedge clk_i) resetn_i = 1;
      rw(12'h230, 0, 8'h00);
      rw(12'h24e, 0, 8'h00);
      chk("pins", 16'h0001, {14'h0, pins});
      report_and_stop();
   end
endmodule
`default_nettype wire
